// ### rss_regs.svh
// Register offsets, field positions, reset values and timing counts of the reset supervisor.
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

`define RSS_ADDR_W              8
`define RSS_DATA_W              32

`define RSS_OFF_CTRL            8'h00
`define RSS_OFF_TRIP            8'h04
`define RSS_OFF_STATUS          8'h08
`define RSS_OFF_WDT_CTRL        8'h0c
`define RSS_OFF_WDT_PERIOD      8'h10
`define RSS_OFF_BUZZ_PERIOD     8'h14
`define RSS_OFF_STATE           8'h18

`define RSS_CTRL_SW_RESET       0
`define RSS_CTRL_SW_BLOCK       1
`define RSS_CTRL_AREG_OFF       2
`define RSS_CTRL_A_UV_RST       3
`define RSS_CTRL_D_UV_RST       4
`define RSS_CTRL_A_UV_EN        5
`define RSS_CTRL_D_UV_EN        6
`define RSS_CTRL_A_OV_EN        7

`define RSS_ST_PRECISE          0
`define RSS_ST_EXTERNAL         1
`define RSS_ST_SOFTWARE         2
`define RSS_ST_WATCHDOG         3
`define RSS_ST_UV_RESET         4
`define RSS_ST_A_UV_IRQ         5
`define RSS_ST_D_UV_IRQ         6
`define RSS_ST_A_OV_IRQ         7

`define RSS_WDT_ENABLE          0
`define RSS_WDT_KICK            1

`define RSS_CTRL_RST            8'h00
`define RSS_TRIP_RST            8'h00
`define RSS_WDT_PERIOD_RST      32'h0001_0000
`define RSS_BUZZ_PERIOD_RST     16'h0400

`define RSS_CLK_PERIOD_NS       8
`define RSS_POR_MIN_NS          150
`define RSS_POR_MIN_CYC         ((`RSS_POR_MIN_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_BUZZ_ON_CYC         16

`endif

// ### rss_pkg.sv
// Types shared by the reset supervisor modules.
package rss_pkg;

  typedef enum logic [2:0]
  {
    RSS_RUN     = 3'b001,
    RSS_HOLD    = 3'b010,
    RSS_STRETCH = 3'b100
  } rss_state_t;

endpackage

// ### rss_ctl_if.sv
// Control and status signals between the supervisor core and its timers.
`timescale 1ns/100ps
`default_nettype none

interface rss_ctl_if;
  logic        clear;
  logic        wdt_en;
  logic        wdt_kick;
  logic [31:0] wdt_period;
  logic        wdt_timeout;
  logic        sleep;
  logic [15:0] buzz_period;
  logic        buzz_active;

  modport core (output clear, wdt_en, wdt_kick, wdt_period, sleep, buzz_period,
                input  wdt_timeout, buzz_active);
  modport wdt  (input  clear, wdt_en, wdt_kick, wdt_period, output wdt_timeout);
  modport buzz (input  clear, sleep, buzz_period, output buzz_active);
endinterface

`default_nettype wire

// ### rss_watchdog.sv
// Watchdog counter that pulses a timeout when firmware stops restarting it.
`timescale 1ns/100ps
`default_nettype none

module rss_watchdog
  import rss_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // Core side
  rss_ctl_if.wdt    ctl
);

  logic [31:0] count;
  wire         expired = (count >= ctl.wdt_period - 32'h1);

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || ctl.clear || !ctl.wdt_en || ctl.wdt_kick)
    begin
      count           <= 32'h0;
      ctl.wdt_timeout <= 1'b0;
    end
    else if (expired)
    begin
      count           <= 32'h0;
      ctl.wdt_timeout <= 1'b1; // R20
    end
    else
    begin
      count           <= count + 32'h1;
      ctl.wdt_timeout <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### rss_buzz_timer.sv
// Sleep-time buzz timer that opens short periodic monitoring windows.
`timescale 1ns/100ps
`default_nettype none
`include "rss_regs.svh"

module rss_buzz_timer
  import rss_pkg::*;
#(
  parameter logic [15:0] ON_CYC = 16'(`RSS_BUZZ_ON_CYC)
)
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // Core side
  rss_ctl_if.buzz   ctl
);

  logic [15:0] count;
  wire         window_end = ctl.buzz_active && (count >= ON_CYC - 16'h1);
  wire         period_end = !ctl.buzz_active && (count >= ctl.buzz_period - 16'h1);

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || ctl.clear || !ctl.sleep)
    begin
      count           <= 16'h0;
      ctl.buzz_active <= 1'b0;
    end
    else if (window_end || period_end)
    begin
      count           <= 16'h0;
      ctl.buzz_active <= period_end; // R09
    end
    else
      count <= count + 16'h1;
  end

endmodule

`default_nettype wire

// ### reset_source_supervisor.sv
// Reset source supervisor: gathers all reset causes and supply monitor events.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rss_regs.svh"

// Summary of operation
// R01: Supply out of range causes reset or interrupt.
// R02: Reset held while external pin is low.
// R03: System reset reinitialises processor and peripherals.
// R04: Status register records causes, cleared at power-on.
// R05: Power-on reset pulse at least 150 ns.
// R06: After boot, precise monitor replaces initial monitor.
// R07: Precise monitor trip equals power-on reset.
// R08: Digital precise monitor undisableable; analog follows regulator.
// R09: Precise monitor off in sleep, buzzed periodically.
// R10: Overvoltage interrupt at fixed 5.75 V level.
// R11: Undervoltage trip levels programmable, 250 mV steps.
// R12: Undervoltage monitors may reset instead of interrupt.
// R13: Interrupt monitors off until boot, buzzed in sleep.
// R14: Buzzed interrupt recognised only after wakeup.
// R15: Firmware keeps buzz period below outage time.
// R16: External pin works in sleep; power-on response.
// R17: External driver waits 10 us before reasserting.
// R18: Software reset bit gives power-on response.
// R19: Separate control bit blocks software reset.
// R20: Watchdog resets when not restarted in time.
// R21: Watchdog disabled after power-on, firmware enables.
// R22: Watchdog enable sticks until power-on reset.
// R23: One system reset, released on clock.
module reset_source_supervisor
  import rss_pkg::*;
#(
  parameter logic [31:0] WDT_PERIOD_RST  = `RSS_WDT_PERIOD_RST,
  parameter logic [15:0] BUZZ_PERIOD_RST = `RSS_BUZZ_PERIOD_RST,
  parameter logic [7:0]  POR_MIN_CYC     = 8'(`RSS_POR_MIN_CYC)
)
(
  // Clock and cold reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Supply comparators
  input  wire logic        initial_supply_reset_i,
  input  wire logic        precise_analog_trip_i,
  input  wire logic        precise_digital_trip_i,
  input  wire logic        analog_undervolt_i,
  input  wire logic        digital_undervolt_i,
  input  wire logic        analog_overvolt_i,
  // External reset pin and power mode
  input  wire logic        external_reset_pin_n_i,
  input  wire logic        sleep_i,
  input  wire logic        hibernate_i,
  // Reset and monitor control
  output logic             system_reset_n_o,
  output logic             initial_monitor_en_o,
  output logic             precise_analog_en_o,
  output logic             precise_digital_en_o,
  output logic             monitor_en_o,
  output logic             buzz_o,
  output logic      [3:0]  analog_trip_sel_o,
  output logic      [3:0]  digital_trip_sel_o,
  // Monitor interrupts and wakeup
  output logic             analog_undervolt_irq_o,
  output logic             digital_undervolt_irq_o,
  output logic             analog_overvolt_irq_o,
  output logic             wake_req_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage

  rss_ctl_if ctl ();

  rss_state_t  state;
  rss_state_t  next_state;
  logic [7:0]  stretch_cnt;
  logic [7:0]  next_stretch_cnt;
  logic        boot_done;
  logic [7:0]  ctrl;
  logic [7:0]  trip;
  logic [7:0]  status;
  logic [2:0]  pending;
  logic        wdt_en;
  logic        wdt_kick;
  logic [31:0] wdt_period;
  logic [15:0] buzz_period;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire wr_ctrl   = wr_i && hit(addr_i, `RSS_OFF_CTRL);
  wire wr_trip   = wr_i && hit(addr_i, `RSS_OFF_TRIP);
  wire wr_status = wr_i && hit(addr_i, `RSS_OFF_STATUS);
  wire wr_wdt    = wr_i && hit(addr_i, `RSS_OFF_WDT_CTRL);
  wire wr_wdtp   = wr_i && hit(addr_i, `RSS_OFF_WDT_PERIOD);
  wire wr_buzz   = wr_i && hit(addr_i, `RSS_OFF_BUZZ_PERIOD);

  // Power-on covers the cold reset and the initial monitor, which only
  // watches the supplies until the first boot has finished.
  wire initial_supply_reset_act  = !boot_done && initial_supply_reset_i; // R06
  wire power_on  = !resetn_i || initial_supply_reset_act;
  wire sys_rst   = (state != RSS_RUN);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset sources

  wire in_sleep  = sleep_i || hibernate_i;
  wire mon_live  = boot_done && !hibernate_i && (!sleep_i || ctl.buzz_active); // R13

  wire next_pd_en = boot_done && !hibernate_i && (!sleep_i || ctl.buzz_active); // R08 R09
  wire next_pa_en = next_pd_en && !ctrl[`RSS_CTRL_AREG_OFF]; // R08

  wire precise_supply_reset_trip = (precise_digital_trip_i && precise_digital_en_o) ||
                   (precise_analog_trip_i && precise_analog_en_o); // R07
  wire external_reset_pin_act  = !external_reset_pin_n_i; // R02 R16
  wire software_reset_request_req  = wr_ctrl && wdata_i[`RSS_CTRL_SW_RESET] &&
                   !ctrl[`RSS_CTRL_SW_BLOCK]; // R18 R19
  wire watchdog_timeout_reset_req  = ctl.wdt_timeout; // R20

  wire a_uv      = mon_live && ctrl[`RSS_CTRL_A_UV_EN] && analog_undervolt_i; // R11
  wire d_uv      = mon_live && ctrl[`RSS_CTRL_D_UV_EN] && digital_undervolt_i; // R11
  wire a_ov      = mon_live && ctrl[`RSS_CTRL_A_OV_EN] && analog_overvolt_i; // R10
  wire uv_rst    = (a_uv && ctrl[`RSS_CTRL_A_UV_RST]) ||
                   (d_uv && ctrl[`RSS_CTRL_D_UV_RST]); // R12
  wire [2:0] irq_evt = {a_ov,
                        d_uv && !ctrl[`RSS_CTRL_D_UV_RST],
                        a_uv && !ctrl[`RSS_CTRL_A_UV_RST]}; // R01

  // Level sources hold the reset; pulse sources start a full-width stretch.
  wire hold_src  = power_on || external_reset_pin_act;
  wire pulse_src = precise_supply_reset_trip || software_reset_request_req || watchdog_timeout_reset_req || uv_rst; // R01

  ////////////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  wire stretch_done = (stretch_cnt >= POR_MIN_CYC - 8'h1);

  always_comb
  begin
    next_state       = state;
    next_stretch_cnt = stretch_cnt;
    if (hold_src)
    begin
      next_state       = RSS_HOLD; // R02
      next_stretch_cnt = 8'h0;
    end
    else
    begin
      case (state)
        RSS_RUN:
        begin
          if (pulse_src)
          begin
            next_state       = RSS_STRETCH; // R07 R18
            next_stretch_cnt = 8'h0;
          end
        end
        RSS_HOLD:
        begin
          next_state       = RSS_STRETCH;
          next_stretch_cnt = 8'h0;
        end
        RSS_STRETCH:
        begin
          if (pulse_src)
            next_stretch_cnt = 8'h0;
          else if (stretch_done)
            next_state = RSS_RUN; // R05
          else
            next_stretch_cnt = stretch_cnt + 8'h1;
        end
        default:
        begin
          next_state       = RSS_HOLD;
          next_stretch_cnt = 8'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      state       <= RSS_HOLD;
      stretch_cnt <= 8'h0;
    end
    else
    begin
      state       <= next_state;
      stretch_cnt <= next_stretch_cnt;
    end
  end

  // Boot is complete at the first release after a power-on reset.
  always_ff @(posedge clk_sys_i)
  begin
    if (power_on)
      boot_done <= 1'b0;
    else if (next_state == RSS_RUN)
      boot_done <= 1'b1; // R06
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers, reinitialised by every system reset except the watchdog enable

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || sys_rst)
    begin
      ctrl        <= `RSS_CTRL_RST; // R03
      trip        <= `RSS_TRIP_RST;
      wdt_period  <= WDT_PERIOD_RST;
      buzz_period <= BUZZ_PERIOD_RST;
      wdt_kick    <= 1'b0;
    end
    else
    begin
      wdt_kick <= wr_wdt && wdata_i[`RSS_WDT_KICK];
      if (wr_ctrl)
        ctrl <= {wdata_i[7:1], 1'b0};
      if (wr_trip)
        trip <= wdata_i[7:0]; // R11
      if (wr_wdtp)
        wdt_period <= wdata_i;
      if (wr_buzz)
        buzz_period <= wdata_i[15:0];
    end
  end

  // The enable survives every reset except power-on and ignores clears.
  always_ff @(posedge clk_sys_i)
  begin
    if (power_on)
      wdt_en <= 1'b0; // R21
    else if (wr_wdt && wdata_i[`RSS_WDT_ENABLE])
      wdt_en <= 1'b1; // R22
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status and monitor interrupts

  // Events seen while buzzing in sleep wait for the wakeup to finish.
  wire [2:0] irq_set  = in_sleep ? 3'h0 : (irq_evt | pending); // R14
  wire [2:0] irq_clr  = wr_status ? wdata_i[`RSS_ST_A_OV_IRQ:`RSS_ST_A_UV_IRQ] : 3'h0;
  wire [2:0] next_irq = irq_set | (status[7:5] & ~irq_clr);

  always_ff @(posedge clk_sys_i)
  begin
    if (power_on)
    begin
      status  <= 8'h00; // R04
      pending <= 3'h0;
    end
    else
    begin
      pending <= in_sleep ? (pending | irq_evt) : 3'h0; // R14
      status[`RSS_ST_PRECISE]  <= status[`RSS_ST_PRECISE] | precise_supply_reset_trip;
      status[`RSS_ST_EXTERNAL] <= status[`RSS_ST_EXTERNAL] | external_reset_pin_act;
      status[`RSS_ST_SOFTWARE] <= status[`RSS_ST_SOFTWARE] | software_reset_request_req;
      status[`RSS_ST_WATCHDOG] <= status[`RSS_ST_WATCHDOG] | watchdog_timeout_reset_req;
      status[`RSS_ST_UV_RESET] <= status[`RSS_ST_UV_RESET] | uv_rst;
      status[7:5]              <= next_irq; // R04
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timers

  assign ctl.clear       = sys_rst;
  assign ctl.wdt_en      = wdt_en;
  assign ctl.wdt_kick    = wdt_kick;
  assign ctl.wdt_period  = wdt_period;
  assign ctl.sleep       = sleep_i && !hibernate_i;
  assign ctl.buzz_period = buzz_period;

  rss_watchdog u_watchdog
  (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ctl       (ctl)
  );

  rss_buzz_timer u_buzz_timer
  (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ctl       (ctl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register read

  wire [31:0] read_mux =
    hit(addr_i, `RSS_OFF_CTRL)        ? {24'h0, ctrl} :
    hit(addr_i, `RSS_OFF_TRIP)        ? {24'h0, trip} :
    hit(addr_i, `RSS_OFF_STATUS)      ? {24'h0, status} :
    hit(addr_i, `RSS_OFF_WDT_CTRL)    ? {31'h0, wdt_en} :
    hit(addr_i, `RSS_OFF_WDT_PERIOD)  ? wdt_period :
    hit(addr_i, `RSS_OFF_BUZZ_PERIOD) ? {16'h0, buzz_period} :
    hit(addr_i, `RSS_OFF_STATE)       ? {26'h0, pending, ctl.buzz_active, in_sleep, boot_done} :
                                        32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Output flops

  // Release leaves on a clock edge only, so peripherals see a clean deassertion;
  // assertion is one edge after the cause since every input is synchronous.
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      system_reset_n_o        <= 1'b0;
      initial_monitor_en_o    <= 1'b1;
      precise_analog_en_o     <= 1'b0;
      precise_digital_en_o    <= 1'b0;
      monitor_en_o            <= 1'b0;
      buzz_o                  <= 1'b0;
      analog_trip_sel_o       <= 4'h0;
      digital_trip_sel_o      <= 4'h0;
      analog_undervolt_irq_o  <= 1'b0;
      digital_undervolt_irq_o <= 1'b0;
      analog_overvolt_irq_o   <= 1'b0;
      wake_req_o              <= 1'b0;
      rdata_o                 <= 32'h0;
    end
    else
    begin
      system_reset_n_o        <= (next_state == RSS_RUN); // R23 R03
      initial_monitor_en_o    <= !boot_done; // R06
      precise_analog_en_o     <= next_pa_en;
      precise_digital_en_o    <= next_pd_en;
      monitor_en_o            <= mon_live; // R13
      buzz_o                  <= ctl.buzz_active; // R09
      analog_trip_sel_o       <= trip[3:0];
      digital_trip_sel_o      <= trip[7:4];
      analog_undervolt_irq_o  <= next_irq[0];
      digital_undervolt_irq_o <= next_irq[1];
      analog_overvolt_irq_o   <= next_irq[2];
      wake_req_o              <= in_sleep && |(pending | irq_evt); // R14
      rdata_o                 <= rd_i ? read_mux : 32'h0;
    end
  end

endmodule

`default_nettype wire

// ### rss_pin_drv.sv
// Behavioural model of the board-level driver of the external reset pin.
`timescale 1ns/100ps
`default_nettype none

module rss_pin_drv
#(
  parameter int GAP_CYC = 1250
)
(
  // Clock
  input  wire logic clk_sys_i,
  // Pin
  output logic      pin_n_o
);
  int gap = 0;

  // The pin has a pull-up, so a released pin reads high.
  initial pin_n_o = 1'b1;

  always @(posedge clk_sys_i)
  begin
    if (!pin_n_o)
      gap <= 0;
    else if (gap < GAP_CYC)
      gap <= gap + 1;
  end

  // A new pulse waits until the pin has been released long enough.
  task automatic pulse(input int n);
    while (gap < GAP_CYC) @(posedge clk_sys_i);
    pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    pin_n_o <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ### rss_monitor.sv
// Port-level assertions of the reset source supervisor.
`timescale 1ns/100ps
`default_nettype none

module rss_monitor
  import rss_pkg::*;
#(
  parameter logic [7:0] POR_MIN_CYC = 8'h13
)
(
  // Clock, reset and register port
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [31:0] rdata_o,
  // Monitors and pin
  input  wire logic        precise_digital_trip_i,
  input  wire logic        analog_overvolt_i,
  input  wire logic        external_reset_pin_n_i,
  input  wire logic        sleep_i,
  input  wire logic        hibernate_i,
  // Outputs watched
  input  wire logic        system_reset_n_o,
  input  wire logic        precise_analog_en_o,
  input  wire logic        precise_digital_en_o,
  input  wire logic        monitor_en_o,
  input  wire logic [3:0]  analog_trip_sel_o,
  input  wire logic [3:0]  digital_trip_sel_o,
  input  wire logic        analog_overvolt_irq_o,
  input  wire logic        wake_req_o
);
  logic [7:0] ctrl;
  logic [7:0] low_cnt;
  wire        ctrl_wr = wr_i && addr_i == 8'h00;
  wire        ov_ev   = analog_overvolt_i && monitor_en_o && ctrl[7] && system_reset_n_o;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Shadow of the control bits; a system reset wipes them as in the block.
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || !system_reset_n_o)
      ctrl <= 8'h00;
    else if (ctrl_wr)
      ctrl <= wdata_i[7:0];
    if (system_reset_n_o)
      low_cnt <= 8'h00;
    else if (!resetn_i)
      low_cnt <= 8'h01;
    else
      low_cnt <= low_cnt + {7'h00, low_cnt != 8'hff};
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_pin_holds_reset: assert property (
    !external_reset_pin_n_i |=> !system_reset_n_o) else $error("pin low without reset");
  a_pin_release_stretch: assert property (
    $rose(external_reset_pin_n_i) |-> !system_reset_n_o [*8]) else $error("stretch too short");
  a_reset_min_width: assert property (
    $rose(system_reset_n_o) |-> low_cnt >= POR_MIN_CYC) else $error("reset pulse too short");
  a_sw_reset_fires: assert property (
    ctrl_wr && wdata_i[0] && !ctrl[1] && system_reset_n_o |=> !system_reset_n_o)
    else $error("software reset ignored");
  a_precise_trip_reset: assert property (
    precise_digital_trip_i && precise_digital_en_o |=> !system_reset_n_o)
    else $error("precise trip ignored");
  a_trip_sel_update: assert property (
    wr_i && addr_i == 8'h04 && system_reset_n_o && external_reset_pin_n_i |-> ##2
    analog_trip_sel_o == $past(wdata_i[3:0], 2) &&
    digital_trip_sel_o == $past(wdata_i[7:4], 2))
    else $error("trip select wrong");
  a_rdata_idle_zero: assert property (
    !rd_i |=> rdata_o == 32'h0) else $error("read data not zero");
  a_overvolt_irq_set: assert property (
    ov_ev && !sleep_i && !hibernate_i |=> analog_overvolt_irq_o) else $error("irq missing");
  a_sleep_wake_req: assert property (
    ov_ev && sleep_i && !hibernate_i ##1 ov_ev |-> wake_req_o)
    else $error("wake request missing");
  a_hibernate_off: assert property (
    hibernate_i |=> !precise_analog_en_o && !precise_digital_en_o)
    else $error("precise monitor on in hibernate");
endmodule

bind reset_source_supervisor rss_monitor #(.POR_MIN_CYC(POR_MIN_CYC)) i_rss_monitor (.*);

`default_nettype wire

// ### reset_source_supervisor_test.sv
// Self-checking testbench of the reset source supervisor.
`timescale 1ns/100ps
`default_nettype none

module reset_source_supervisor_test
  import rss_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i = 1'b0, rd_i = 1'b0, pa_trip = 1'b0, pd_trip = 1'b0;
  logic        a_uv = 1'b0, d_uv = 1'b0, a_ov = 1'b0, sleep_i = 1'b0, hib_i = 1'b0;
  logic [31:0] rdata_o;
  logic        pin_n, rst_n, init_en, pa_en, pd_en, mon_en, buzz, aov_irq, wake;
  logic        auv_irq, duv_irq;
  logic [3:0]  a_sel, d_sel;
  int          bad_count = 0;
  int          n_tests   = 0;
  logic [31:0] st        = 32'h0;

  reset_source_supervisor #(.WDT_PERIOD_RST(32'h20)) i_reset_source_supervisor (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .initial_supply_reset_i(1'b0),
    .precise_analog_trip_i(pa_trip), .precise_digital_trip_i(pd_trip),
    .analog_undervolt_i(a_uv), .digital_undervolt_i(d_uv), .analog_overvolt_i(a_ov),
    .external_reset_pin_n_i(pin_n), .sleep_i(sleep_i), .hibernate_i(hib_i),
    .system_reset_n_o(rst_n), .initial_monitor_en_o(init_en), .precise_analog_en_o(pa_en),
    .precise_digital_en_o(pd_en), .monitor_en_o(mon_en), .buzz_o(buzz),
    .analog_trip_sel_o(a_sel), .digital_trip_sel_o(d_sel), .analog_undervolt_irq_o(auv_irq),
    .digital_undervolt_irq_o(duv_irq), .analog_overvolt_irq_o(aov_irq), .wake_req_o(wake));

  rss_pin_drv i_rss_pin_drv (.clk_sys_i(clk_sys_i), .pin_n_o(pin_n));

  initial forever #4 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample it there.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    @(negedge clk_sys_i);
    chk($sformatf("read %h", a), e, rdata_o);
  endtask

  task automatic wait_on(ref logic s, input logic v, input string n);
    for (int i = 0; i < 300 && s !== v; i++) @(negedge clk_sys_i);
    chk(n, {31'h0, v}, {31'h0, s});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    wait_on(rst_n, 1'b1, "boot");
    rd(8'h10, 32'h20);
    rd(8'h14, 32'h400);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h40, 32'h0);
    chk("initial monitor", 32'h0, {31'h0, init_en});
    $display("test defaults finished");
    for (int n = 0; n < 16; n++)
    begin
      wr(8'h04, {24'h0, 4'(15 - n), 4'(n)});
      repeat (2) @(negedge clk_sys_i);
      chk("trip sel", {24'h0, 4'(15 - n), 4'(n)}, {24'h0, d_sel, a_sel});
    end
    wr(8'h00, 32'h04);
    repeat (2) @(negedge clk_sys_i);
    chk("precise en", 32'h1, {30'h0, pa_en, pd_en});
    $display("test trip and regulator finished");
    wr(8'h00, 32'h02);
    wr(8'h00, 32'h03);
    repeat (4) @(negedge clk_sys_i);
    chk("blocked", 32'h1, {31'h0, rst_n});
    wr(8'h00, 32'h00);
    wr(8'h00, 32'h01);
    wait_on(rst_n, 1'b0, "sw reset");
    wait_on(rst_n, 1'b1, "sw release");
    st = 32'h04;
    rd(8'h04, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h08, st);
    $display("test software reset finished");
    @(posedge clk_sys_i);
    hib_i <= 1'b1;
    i_rss_pin_drv.pulse(30);
    @(negedge clk_sys_i);
    chk("pin reset", 32'h0, {31'h0, rst_n});
    chk("monitor off", 32'h0, {31'h0, mon_en});
    @(posedge clk_sys_i);
    hib_i <= 1'b0;
    wait_on(rst_n, 1'b1, "pin release");
    st |= 32'h02;
    rd(8'h08, st);
    $display("test external pin finished");
    @(posedge clk_sys_i);
    pd_trip <= 1'b1;
    @(posedge clk_sys_i);
    pd_trip <= 1'b0;
    wait_on(rst_n, 1'b0, "precise trip");
    wait_on(rst_n, 1'b1, "precise release");
    st |= 32'h01;
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, k ? 32'h50 : 32'h28);
      repeat (3) @(posedge clk_sys_i);
      a_uv <= (k == 0);
      d_uv <= (k == 1);
      @(posedge clk_sys_i);
      a_uv <= 1'b0;
      d_uv <= 1'b0;
      wait_on(rst_n, 1'b0, "undervolt reset");
      wait_on(rst_n, 1'b1, "undervolt release");
    end
    st |= 32'h10;
    rd(8'h08, st);
    $display("test supply resets finished");
    wr(8'h00, 32'h80);
    repeat (3) @(posedge clk_sys_i);
    a_ov <= 1'b1;
    @(posedge clk_sys_i);
    a_ov <= 1'b0;
    @(negedge clk_sys_i);
    chk("overvolt irq", 32'h1, {31'h0, aov_irq});
    rd(8'h08, st | 32'h80);
    wr(8'h08, 32'h80);
    repeat (2) @(negedge clk_sys_i);
    chk("irq cleared", 32'h0, {31'h0, aov_irq});
    wr(8'h00, 32'he0);
    repeat (3) @(posedge clk_sys_i);
    a_uv <= 1'b1;
    d_uv <= 1'b1;
    @(posedge clk_sys_i);
    a_uv <= 1'b0;
    d_uv <= 1'b0;
    @(negedge clk_sys_i);
    chk("undervolt irq", 32'h3, {30'h0, duv_irq, auv_irq});
    st |= 32'h60;
    wr(8'h14, 32'h40);
    @(posedge clk_sys_i);
    sleep_i <= 1'b1;
    wait_on(buzz, 1'b1, "buzz");
    @(posedge clk_sys_i);
    a_ov <= 1'b1;
    wait_on(wake, 1'b1, "wake");
    chk("irq in sleep", 32'h0, {31'h0, aov_irq});
    @(posedge clk_sys_i);
    a_ov    <= 1'b0;
    sleep_i <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk("irq after wake", 32'h1, {31'h0, aov_irq});
    st |= 32'h80;
    $display("test monitor irq finished");
    wr(8'h0c, 32'h1);
    wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h1);
    repeat (4)
    begin
      repeat (16) @(posedge clk_sys_i);
      wr(8'h0c, 32'h3);
    end
    @(negedge clk_sys_i);
    chk("kicked", 32'h1, {31'h0, rst_n});
    wait_on(rst_n, 1'b0, "watchdog reset");
    wait_on(rst_n, 1'b1, "watchdog release");
    st |= 32'h08;
    rd(8'h08, st);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    wait_on(rst_n, 1'b1, "cold release");
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h0);
    $display("test watchdog finished");
    print_verdict();
  end
endmodule

`default_nettype wire
